//--- fecl_pkg.sv
// constants of the framer error-count latch and second irq mask block
// assumes one 100 MHz clock and an AXI4-Lite master holding 8-bit registers
//
// Overview of operation
// R01 - mask bits 7..5 gate rx multiframe, tx multiframe, one-second timer; 1 enables
// R02 - mask bits 4..1 gate link buffer full, empty, match, abort; 1 enables
// R03 - software writes zero into mask bit 0, which is unassigned
// R04 - three error counters per framer cover violations, path errors, out-of-sync multiframes
// R05 - interval select 0 updates on one-second boundaries, 1 every 42 ms
// R06 - automatic updates come from the timer that sets the one-second flag
// R07 - with manual enable set, only the manual trigger updates the registers
// R08 - latched values hold until the next update, then are overwritten
// R09 - counters saturate at maximum and never wrap
// R10 - software reads counters after the timer interrupt, before the next update
// R11 - line violation counter is 16 bits, high byte in first register
// R12 - path violation counter is 12 bits, crc6 or framing bit errors
// R13 - each update copies the running count and restarts it from zero
package fecl_pkg;
    // ********************************
    // bus
    // ********************************
    localparam int         ADDR_W        = 10;
    localparam int         DATA_W        = 32;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    // ********************************
    // register indices, byte address is four times the index
    // ********************************
    localparam logic [7:0] IDX_LINE_HI   = 8'hC3;
    localparam logic [7:0] IDX_LINE_LO   = 8'hC4;
    localparam logic [7:0] IDX_PATH_HI   = 8'hC5;
    localparam logic [7:0] IDX_PATH_LO   = 8'hC6;
    localparam logic [7:0] IDX_MOS_LO    = 8'hC7;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'hEF;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'hF0;
    localparam logic [7:0] IDX_CTRL      = 8'hF1;
    // ********************************
    // fields
    // ********************************
    localparam int         BIT_RX_MF     = 7;
    localparam int         BIT_TX_MF     = 6;
    localparam int         BIT_TIMER     = 5;
    localparam int         BIT_RX_FULL   = 4;
    localparam int         BIT_TX_EMPTY  = 3;
    localparam int         BIT_MATCH     = 2;
    localparam int         BIT_ABORT     = 1;
    localparam int         BIT_LOW_SRC   = 1;
    localparam int         CTL_INTERVAL  = 0;
    localparam int         CTL_MAN_EN    = 1;
    localparam int         CTL_MAN_TRIG  = 2;
    localparam logic [7:0] MASK_USED     = 8'hFE;
    localparam logic [7:0] CTRL_USED     = 8'h07;
    localparam logic [7:0] MASK_RST      = 8'h00;
    localparam logic [7:0] STAT_RST      = 8'h00;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam int         LINE_W        = 16;
    localparam int         PATH_W        = 12;
    localparam int         MOS_W         = 12;
    // ********************************
    // timing
    // ********************************
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         LONG_MS       = 1000;
    localparam int         SHORT_MS      = 42;
    localparam int         LONG_CYC      = LONG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int         SHORT_CYC     = SHORT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int         TIMER_W       = 27;
endpackage

//--- fecl_top.sv
// error counters with timed or manual latching, and the second irq mask of framer b
// assumes error and irq source inputs are one-cycle pulses from logic on clk_sys
`timescale 1ns/10ps
module fecl_top #(
    parameter int LONG_CYC  = fecl_pkg::LONG_CYC,
    parameter int SHORT_CYC = fecl_pkg::SHORT_CYC
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic [fecl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [fecl_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [fecl_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [fecl_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        line_violation_event,
    input  wire logic                        path_violation_event,
    input  wire logic                        out_of_sync_multiframe_event,
    input  wire logic                        rx_sync_loss,
    input  wire logic                        rx_multiframe_irq,
    input  wire logic                        tx_multiframe_irq,
    input  wire logic                        rx_link_buffer_full_irq,
    input  wire logic                        tx_link_buffer_empty_irq,
    input  wire logic                        rx_link_match_irq,
    input  wire logic                        rx_link_abort_irq,
    output logic                             one_second_timer_flag,
    output logic                             irq
);
    import fecl_pkg::*;

    // ********************************
    // state
    // ********************************
    logic              aw_held_reg;
    logic [7:0]        aw_idx_reg;
    logic              w_held_reg;
    logic [7:0]        w_byte_reg;
    logic              w_lane_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [7:0]        rbyte_reg;
    logic [1:0]        rresp_reg;
    logic [7:0]        mask_reg;
    logic [7:0]        stat_reg;
    logic [7:0]        ctrl_reg;
    logic              trig_prev_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic              irq_reg;
    logic [LINE_W-1:0] line_run_reg;
    logic [LINE_W-1:0] line_hold_reg;
    logic [PATH_W-1:0] path_run_reg;
    logic [PATH_W-1:0] path_hold_reg;
    logic [MOS_W-1:0]  mos_run_reg;
    logic [MOS_W-1:0]  mos_hold_reg;

    logic              do_write;
    logic              wr_hit;
    logic              wr_en;
    logic              tick;
    logic              trig_rise;
    logic              upd;
    logic [TIMER_W-1:0] period_last;
    logic [7:0]        src;
    logic [7:0]        rd_byte;
    logic              rd_hit;
    // ********************************
    // axi4-lite write path
    // ********************************
    // address and data latch separately so either may arrive first
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_hit        = (aw_idx_reg == IDX_IRQ_MASK) || (aw_idx_reg == IDX_IRQ_STAT)
                           || (aw_idx_reg == IDX_CTRL);
    assign wr_en         = do_write && wr_hit && w_lane_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg  <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[9:2];
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            w_held_reg <= 1'b0;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_byte_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // ********************************
    // axi4-lite read path
    // ********************************
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (s_axi_araddr[9:2])
            IDX_LINE_HI:  rd_byte = line_hold_reg[15:8]; // R11
            IDX_LINE_LO:  rd_byte = line_hold_reg[7:0];
            IDX_PATH_HI:  rd_byte = {mos_hold_reg[11:8], path_hold_reg[11:8]}; // R12
            IDX_PATH_LO:  rd_byte = path_hold_reg[7:0];
            IDX_MOS_LO:   rd_byte = mos_hold_reg[7:0];
            IDX_IRQ_MASK: rd_byte = mask_reg;
            IDX_IRQ_STAT: rd_byte = stat_reg;
            IDX_CTRL:     rd_byte = ctrl_reg;
            default:      rd_hit  = 1'b0;
        endcase
    end

    assign s_axi_arready = !rvalid_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rbyte_reg  <= 8'h00;
            rresp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rbyte_reg  <= rd_byte;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = {24'h000000, rbyte_reg};
    assign s_axi_rresp  = rresp_reg;

    // ********************************
    // control and mask registers
    // ********************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask_reg <= MASK_RST;
        end else if (wr_en && aw_idx_reg == IDX_IRQ_MASK) begin
            // bit 0 is unassigned and kept at zero whatever is written
            mask_reg <= w_byte_reg & MASK_USED; // R03
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_en && aw_idx_reg == IDX_CTRL) begin
            ctrl_reg <= w_byte_reg & CTRL_USED;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= ctrl_reg[CTL_MAN_TRIG];
        end
    end

    // ********************************
    // update timer and update event
    // ********************************
    assign period_last = ctrl_reg[CTL_INTERVAL] ? TIMER_W'(SHORT_CYC - 1)
                                                : TIMER_W'(LONG_CYC - 1); // R05
    // >= so a switch to the short interval never strands the count
    assign tick        = (timer_reg >= period_last);
    assign trig_rise   = ctrl_reg[CTL_MAN_TRIG] && !trig_prev_reg;
    assign upd         = ctrl_reg[CTL_MAN_EN] ? trig_rise : tick; // R07 R06

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer_reg <= '0;
        end else if (tick) begin
            timer_reg <= '0;
        end else begin
            timer_reg <= timer_reg + TIMER_W'(1);
        end
    end

    // ********************************
    // error counters, running and latched
    // ********************************
    // an event in the update cycle starts the new interval at one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            line_run_reg  <= '0;
            line_hold_reg <= '0;
        end else if (upd) begin
            line_hold_reg <= line_run_reg; // R08 R13
            line_run_reg  <= LINE_W'(line_violation_event);
        end else if (line_violation_event && line_run_reg != '1) begin
            line_run_reg  <= line_run_reg + LINE_W'(1); // R04 R09 R11
        end
    end

    logic path_count;
    // path errors are meaningless without receive sync
    assign path_count = path_violation_event && !rx_sync_loss;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            path_run_reg  <= '0;
            path_hold_reg <= '0;
        end else if (upd) begin
            path_hold_reg <= path_run_reg; // R08 R13
            path_run_reg  <= PATH_W'(path_count);
        end else if (path_count && path_run_reg != '1) begin
            path_run_reg  <= path_run_reg + PATH_W'(1); // R04 R09 R12
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mos_run_reg  <= '0;
            mos_hold_reg <= '0;
        end else if (upd) begin
            mos_hold_reg <= mos_run_reg; // R08 R13
            mos_run_reg  <= MOS_W'(out_of_sync_multiframe_event);
        end else if (out_of_sync_multiframe_event && mos_run_reg != '1) begin
            mos_run_reg  <= mos_run_reg + MOS_W'(1); // R04 R09
        end
    end

    // ********************************
    // interrupt status and output
    // ********************************
    always_comb begin
        src               = 8'h00;
        src[BIT_RX_MF]    = rx_multiframe_irq;
        src[BIT_TX_MF]    = tx_multiframe_irq;
        src[BIT_TIMER]    = tick; // R06
        src[BIT_RX_FULL]  = rx_link_buffer_full_irq;
        src[BIT_TX_EMPTY] = tx_link_buffer_empty_irq;
        src[BIT_MATCH]    = rx_link_match_irq;
        src[BIT_ABORT]    = rx_link_abort_irq;
    end
    assign stat_reg[0] = 1'b0;
    generate
        for (genvar i = BIT_LOW_SRC; i < 8; i++) begin : g_stat
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    stat_reg[i] <= STAT_RST[i];
                end else if (src[i]) begin
                    // a new event beats a simultaneous clear
                    stat_reg[i] <= 1'b1;
                end else if (wr_en && aw_idx_reg == IDX_IRQ_STAT && w_byte_reg[i]) begin
                    stat_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(stat_reg & mask_reg); // R01 R02
        end
    end
    assign irq                   = irq_reg;
    assign one_second_timer_flag = stat_reg[BIT_TIMER];
    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence quiet_8;
        !tick [*8];
    endsequence
    sequence latched_now;
        line_hold_reg == $past(line_run_reg) && path_hold_reg == $past(path_run_reg)
            && mos_hold_reg == $past(mos_run_reg);
    endsequence
    irq_follow_a: assert property ( // R01
        ##1 (irq == $past(|(stat_reg & mask_reg)))
    ) else $error("irq does not follow masked status");
    link_gate_a: assert property ( // R02
        (stat_reg[BIT_ABORT] && mask_reg[BIT_ABORT]) |=> irq
    ) else $error("enabled link abort did not raise irq");
    mask_bit0_a: assert property ( // R03
        mask_reg[0] == 1'b0
    ) else $error("unassigned mask bit is set");
    tick_spacing_a: assert property ( // R05
        tick |=> quiet_8
    ) else $error("update timer ticks too close together");
    timer_flag_a: assert property ( // R06
        (tick && !ctrl_reg[CTL_MAN_EN]) |=> (stat_reg[BIT_TIMER] && $past(upd))
    ) else $error("timer flag and update do not coincide");
    manual_only_a: assert property ( // R07
        (ctrl_reg[CTL_MAN_EN] && !trig_rise) |=> $stable(line_hold_reg) && $stable(mos_hold_reg)
    ) else $error("latched count changed without manual trigger");
    hold_stable_a: assert property ( // R08
        !upd |=> $stable(line_hold_reg) && $stable(path_hold_reg)
    ) else $error("latched count changed between updates");
    line_sat_a: assert property ( // R09
        (line_run_reg == '1 && !upd) |=> line_run_reg == '1
    ) else $error("line counter wrapped");
    copy_restart_a: assert property ( // R13
        upd |=> latched_now and (line_run_reg <= LINE_W'(1))
    ) else $error("update did not copy and restart counters");
endmodule

//--- fecl_top_tb.sv
// self-checking bench for the error-count latch and second irq mask block
// assumes fecl_pkg is compiled first; timer counts are shortened by parameter
`timescale 1ns/10ps
module fecl_top_tb;
    import fecl_pkg::*;
    // ********************************
    // signals
    // ********************************
    localparam int      T_LONG  = 200;
    localparam int      T_SHORT = 40;
    logic               clk_sys, rst;
    logic [ADDR_W-1:0]  awaddr, araddr;
    logic [DATA_W-1:0]  wdata, rdata;
    logic [3:0]         wstrb;
    logic               awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready;
    logic [1:0]         bresp, rresp;
    logic               ev_line, ev_path, ev_mos, sync_loss, flag, irq;
    logic [7:0]         src;
    logic [3:0]         strb_sel;
    int                 error_cnt, checked;

    fecl_top #(.LONG_CYC(T_LONG), .SHORT_CYC(T_SHORT)) u_fecl_top (
        .clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .line_violation_event(ev_line), .path_violation_event(ev_path),
        .out_of_sync_multiframe_event(ev_mos), .rx_sync_loss(sync_loss),
        .rx_multiframe_irq(src[7]), .tx_multiframe_irq(src[6]),
        .rx_link_buffer_full_irq(src[4]), .tx_link_buffer_empty_irq(src[3]),
        .rx_link_match_irq(src[2]), .rx_link_abort_irq(src[1]),
        .one_second_timer_flag(flag), .irq(irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ********************************
    // common tasks
    // ********************************
    task automatic tally_and_finish();
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timed_out();
        error_cnt++;
        $display("Error at %0t: wait ran out", $time);
        tally_and_finish();
    endtask

    // readies are combinational, so handshakes are judged at the settled negedge
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic a, w, b;
        b = 1'b0;
        @(posedge clk_sys);
        awaddr  <= {idx, 2'h0};
        wdata   <= {24'h0, d};
        wstrb   <= strb_sel;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 50 && !b; n++) begin
            @(negedge clk_sys);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            if (b) check({30'h0, bresp}, {30'h0, er});
            @(posedge clk_sys);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
        if (!b) timed_out();
    endtask

    task automatic rd(input logic [7:0] idx, input logic [1:0] er, output logic [31:0] d);
        logic a, r;
        r = 1'b0;
        d = 'x;
        @(posedge clk_sys);
        araddr  <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 50 && !r; n++) begin
            @(negedge clk_sys);
            a = arvalid && arready;
            r = rvalid && rready;
            if (r) begin
                check({30'h0, rresp}, {30'h0, er});
                d = rdata;
            end
            @(posedge clk_sys);
            if (a) arvalid <= 1'b0;
            if (r) rready <= 1'b0;
        end
        if (!r) timed_out();
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        rd(idx, RESP_OKAY, d);
        check(d, {24'h0, exp});
    endtask

    task automatic rd_cnt(input logic [15:0] l, input logic [11:0] p, input logic [11:0] m);
        rdc(IDX_LINE_HI, l[15:8]);
        rdc(IDX_LINE_LO, l[7:0]);
        rdc(IDX_PATH_HI, {m[11:8], p[11:8]});
        rdc(IDX_PATH_LO, p[7:0]);
        rdc(IDX_MOS_LO, m[7:0]);
    endtask

    // one count per high cycle, each line held for its own number of cycles
    task automatic ev(input int nl, input int np, input int nm);
        for (int i = 0; i < nl || i < np || i < nm; i++) begin
            @(posedge clk_sys);
            ev_line <= (i < nl);
            ev_path <= (i < np);
            ev_mos  <= (i < nm);
        end
        @(posedge clk_sys);
        {ev_line, ev_path, ev_mos} <= 3'h0;
    endtask

    task automatic trig();
        wr(IDX_CTRL, 8'h02, RESP_OKAY);
        wr(IDX_CTRL, 8'h06, RESP_OKAY);
    endtask

    task automatic wait_flag(output time t);
        int n;
        for (n = 0; n < 1000 && flag !== 1'b1; n++) @(negedge clk_sys);
        if (n == 1000) timed_out();
        t = $time;
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic sc_regs();
        logic [31:0] d;
        rdc(IDX_IRQ_MASK, MASK_RST);
        rdc(IDX_CTRL, CTRL_RST);
        rd(8'h10, RESP_SLVERR, d);
        wr(IDX_LINE_HI, 8'h55, RESP_SLVERR);
        wr(IDX_IRQ_MASK, 8'hFE, RESP_OKAY);
        rdc(IDX_IRQ_MASK, 8'hFE);
        // a write without lane 0 is answered but leaves the register alone
        strb_sel = 4'hE;
        wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
        strb_sel = 4'hF;
        rdc(IDX_IRQ_MASK, 8'hFE);
    endtask

    task automatic sc_mask();
        logic [31:0] d;
        for (int b = 1; b < 8; b++) begin
            if (b == BIT_TIMER) continue;
            wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
            @(posedge clk_sys) src[b] <= 1'b1;
            @(posedge clk_sys) src[b] <= 1'b0;
            repeat (3) @(negedge clk_sys);
            check({31'h0, irq}, 32'h0);
            rd(IDX_IRQ_STAT, RESP_OKAY, d);
            check({31'h0, d[b]}, 32'h1);
            wr(IDX_IRQ_MASK, 8'h01 << b, RESP_OKAY);
            repeat (2) @(negedge clk_sys);
            check({31'h0, irq}, 32'h1);
            wr(IDX_IRQ_STAT, 8'h01 << b, RESP_OKAY);
            repeat (2) @(negedge clk_sys);
            check({31'h0, irq}, 32'h0);
        end
    endtask

    task automatic sc_manual();
        trig();
        ev(5, 3, 2);
        @(posedge clk_sys) sync_loss <= 1'b1;
        ev(0, 2, 0);
        @(posedge clk_sys) sync_loss <= 1'b0;
        trig();
        rd_cnt(16'd5, 12'd3, 12'd2);
        repeat (T_LONG + 50) @(posedge clk_sys);
        rd_cnt(16'd5, 12'd3, 12'd2);
        trig();
        rd_cnt(16'd0, 12'd0, 12'd0);
        // the line count reaches its 16-bit ceiling after 65535 events; more are driven
        ev(65540, 4100, 4100);
        trig();
        rd_cnt(16'hFFFF, 12'hFFF, 12'hFFF);
    endtask

    // each clear after the first follows a seen flag, so it never meets the next tick
    task automatic sc_auto();
        time t1, t2;
        wr(IDX_CTRL, 8'h00, RESP_OKAY);
        wr(IDX_IRQ_MASK, 8'h20, RESP_OKAY);
        wr(IDX_IRQ_STAT, 8'hFF, RESP_OKAY);
        wait_flag(t1);
        wr(IDX_IRQ_STAT, 8'h20, RESP_OKAY);
        wait_flag(t1);
        @(negedge clk_sys);
        check({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_STAT, 8'h20, RESP_OKAY);
        ev(7, 4, 1);
        wait_flag(t2);
        check(32'(t2 - t1), 32'(T_LONG * 10));
        rd_cnt(16'd7, 12'd4, 12'd1);
        wr(IDX_CTRL, 8'h01, RESP_OKAY);
        wr(IDX_IRQ_STAT, 8'h20, RESP_OKAY);
        wait_flag(t1);
        wr(IDX_IRQ_STAT, 8'h20, RESP_OKAY);
        wait_flag(t1);
        wr(IDX_IRQ_STAT, 8'h20, RESP_OKAY);
        wait_flag(t2);
        check(32'(t2 - t1), 32'(T_SHORT * 10));
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        error_cnt = 0;
        checked   = 0;
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = '0;
        araddr = '0;
        wdata  = '0;
        wstrb  = 4'h0;
        strb_sel = 4'hF;
        {ev_line, ev_path, ev_mos, sync_loss} = 4'h0;
        src = 8'h00;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        sc_regs();
        sc_mask();
        sc_manual();
        sc_auto();
        tally_and_finish();
    end
endmodule
